/* core/reg_test_interp.sv */
// Regulatory test command interpreter: direct test mode and cellular test commands.
// Function
// [RULE1] Each test command is 16 bits, one reply.
// [RULE2] Bytes travel most significant first.
// [RULE3] Command, control, parameter, trailing zero fields.
// [RULE4] Control 6 sets power 0 to 17 dBm.
// [RULE5] Power reply gives the power really applied.
// [RULE6] Control 7 sets or removes carrier override.
// [RULE7] Test mode switch, disabled by default.
// [RULE8] Association indication reads 0x31 in test mode.
// [RULE9] Host starts test before other test commands.
// [RULE10] Stop ends any test in progress; the code leaves a direct test mode transmit or receive running.
// [RULE11] Modulated transmit on stored channel until stopped.
// [RULE12] Set channel stores 0 to 65535.
// [RULE13] Get channel returns stored channel.
// [RULE14] Set power takes 12-bit sixteenths of dBm.
// [RULE15] Only whole dBm applied, -40 to 24.
// [RULE16] Get power returns stored power.
// [RULE17] Start receive on stored channel.
// [RULE18] Channel mapping 0, 1 or 4.
// [RULE19] Host polls status until wanted state.
// [RULE20] Host follows enable, start, test, stop, disable.
// [RULE21] Api mode 0 routes to direct test mode.
// [RULE22] Status codes 0 to 5.
// [RULE23] Early or out-of-range commands are rejected.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "reg_test_map.svh"
module reg_test_interp (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Register port.
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Direct test mode byte stream from and to the serial port.
  input wire logic dtm_rx_valid_in,
  input wire logic [7:0] dtm_rx_byte_in,
  output logic dtm_tx_valid_out,
  output logic [7:0] dtm_tx_byte_out,
  // Cellular test command port.
  input wire logic at_valid_in,
  input wire reg_test_pkg::at_req_type at_req_in,
  output logic at_rsp_valid_out,
  output reg_test_pkg::at_rsp_type at_rsp_out,
  // Radio side.
  input wire logic radio_ack_in,
  input wire logic radio_fail_in,
  output reg_test_pkg::radio_ctl_type radio_ctl_out,
  output logic modem_on_out,
  output logic feature_enable_out,
  output logic cellular_normal_out,
  output logic [7:0] association_indication_out
);
  import reg_test_pkg::*;

  // =========================================================================
  // Cellular test state.
  logic test_enabled, next_test_enabled;
  logic test_started, next_test_started;
  test_state_type state, next_state;
  test_state_type target, next_target;
  logic at_tx, next_at_tx;
  logic at_rx, next_at_rx;
  logic [15:0] channel, next_channel;
  logic [11:0] power, next_power;
  logic [2:0] channel_map, next_channel_map;
  logic next_rsp_valid;
  at_rsp_type next_rsp;
  logic [7:0] whole_dbm;

  // Whole dBm is the arithmetic shift of the sixteenths value, so -1/16 reads as -1.
  assign whole_dbm = at_req_in.arg[11:4];

  // Command decode and radio handshake; each command answers one cycle later.
  always_comb begin
    next_test_enabled = test_enabled;
    next_test_started = test_started;
    next_state = state;
    next_target = target;
    next_at_tx = at_tx;
    next_at_rx = at_rx;
    next_channel = channel;
    next_power = power;
    next_channel_map = channel_map;
    next_rsp_valid = at_valid_in;
    next_rsp = '{err: 1'b0, data: 16'h0000};
    // A pending transition completes on the radio's acknowledge; errors may be transient.
    if ((state == ST_TRANSITION || state == ST_ERROR) && radio_ack_in) begin
      next_state = target; // [RULE19]
    end else if (state == ST_TRANSITION && radio_fail_in) begin
      next_state = ST_ERROR;
    end
    if (at_valid_in) begin
      unique case (at_req_in.cmd)
        CMD_ENABLE: begin
          if (at_req_in.arg > 16'h0001) begin
            next_rsp.err = 1'b1; // [RULE23]
          end else begin
            next_test_enabled = at_req_in.arg[0]; // [RULE7]
            if (!at_req_in.arg[0]) begin
              next_test_started = 1'b0;
              next_state = ST_INACTIVE;
              next_at_tx = 1'b0;
              next_at_rx = 1'b0;
            end
          end
        end
        CMD_START: begin
          if (!test_enabled) begin
            next_rsp.err = 1'b1;
          end else begin
            next_test_started = 1'b1; // [RULE9]
            next_state = ST_TRANSITION;
            next_target = ST_OFF;
          end
        end
        CMD_QUERY: begin
          next_rsp.data = {13'h0000, state}; // [RULE22]
        end
        default: begin
          // Every other command needs a started test mode.
          if (!test_started) begin
            next_rsp.err = 1'b1; // [RULE23]
          end else begin
            unique case (at_req_in.cmd)
              CMD_STOP: begin
                next_test_started = 1'b0; // [RULE10]
                next_state = ST_INACTIVE;
                next_at_tx = 1'b0;
                next_at_rx = 1'b0;
              end
              CMD_TX_START: begin
                next_at_tx = 1'b1; // [RULE11]
                next_at_rx = 1'b0;
                next_state = ST_TRANSITION;
                next_target = ST_TRANSMIT;
              end
              CMD_TX_STOP: begin
                next_at_tx = 1'b0;
                next_state = ST_OFF;
              end
              CMD_SET_CHAN: next_channel = at_req_in.arg; // [RULE12]
              CMD_GET_CHAN: next_rsp.data = channel; // [RULE13]
              CMD_SET_PWR: begin
                if (at_req_in.arg > `PWR_ARG_MAX ||
                    $signed(whole_dbm) < $signed(`PWR_MIN_DBM) ||
                    $signed(whole_dbm) > $signed(`PWR_MAX_DBM)) begin
                  next_rsp.err = 1'b1; // [RULE23]
                end else begin
                  next_power = at_req_in.arg[11:0]; // [RULE14]
                end
              end
              CMD_GET_PWR: next_rsp.data = {4'h0, power}; // [RULE16]
              CMD_RX_START: begin
                next_at_rx = 1'b1; // [RULE17]
                next_at_tx = 1'b0;
                next_state = ST_TRANSITION;
                next_target = ST_RECEIVE;
              end
              CMD_SET_MAP: begin
                if (at_req_in.arg == {13'h0000, `MAP_GSM} ||
                    at_req_in.arg == {13'h0000, `MAP_PCS} ||
                    at_req_in.arg == {13'h0000, `MAP_LTE}) begin
                  next_channel_map = at_req_in.arg[2:0]; // [RULE18]
                end else begin
                  next_rsp.err = 1'b1;
                end
              end
              CMD_GET_MAP: next_rsp.data = {13'h0000, channel_map};
              default: next_rsp.err = 1'b1;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      test_enabled <= 1'b0;
      test_started <= 1'b0;
      state <= ST_INACTIVE;
      target <= ST_OFF;
      at_tx <= 1'b0;
      at_rx <= 1'b0;
      channel <= 16'h0000;
      power <= 12'h000;
      channel_map <= `MAP_LTE;
      at_rsp_valid_out <= 1'b0;
      at_rsp_out <= '{err: 1'b0, data: 16'h0000};
    end else begin
      test_enabled <= next_test_enabled;
      test_started <= next_test_started;
      state <= next_state;
      target <= next_target;
      at_tx <= next_at_tx;
      at_rx <= next_at_rx;
      channel <= next_channel;
      power <= next_power;
      channel_map <= next_channel_map;
      at_rsp_valid_out <= next_rsp_valid;
      at_rsp_out <= next_rsp;
    end
  end

  // =========================================================================
  // Registers on the plain port.
  logic [7:0] ctrl, next_ctrl;
  logic [5:0] max_pwr, next_max_pwr;
  logic [31:0] next_rdata;

  // Reads answer in the next cycle; unmapped offsets read zero.
  always_comb begin
    next_ctrl = ctrl;
    next_max_pwr = max_pwr;
    next_rdata = 32'h0000_0000;
    if (reg_wr_in && reg_addr_in == `REG_CTRL) begin
      next_ctrl = reg_wdata_in[7:0];
    end
    if (reg_wr_in && reg_addr_in == `REG_MAXPWR) begin
      next_max_pwr = reg_wdata_in[5:0];
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `REG_CTRL: next_rdata = {24'h000000, ctrl};
        `REG_MAXPWR: next_rdata = {26'h0000000, max_pwr};
        `REG_STATUS: next_rdata = {16'h0000, association_indication_out, 3'h0,
                                   test_started, test_enabled, state};
        `REG_SETTINGS: next_rdata = {4'h0, power, channel};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= `CTRL_RESET;
      max_pwr <= `MAXPWR_RESET;
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      max_pwr <= next_max_pwr;
      reg_rdata_out <= next_rdata;
    end
  end

  // =========================================================================
  // Direct test mode: two bytes in, two bytes out, most significant first.
  logic have_msb, next_have_msb;
  logic [7:0] msb, next_msb;
  logic lsb_pending, next_lsb_pending;
  logic [7:0] lsb, next_lsb;
  logic dtm_tx, next_dtm_tx;
  logic dtm_rx, next_dtm_rx;
  logic carrier, next_carrier;
  logic [5:0] dtm_power, next_dtm_power;
  logic next_tx_valid;
  logic [7:0] next_tx_byte;
  logic [15:0] word, answer;
  logic [5:0] cap, applied;
  logic dtm_route;

  assign dtm_route = (ctrl[`CTRL_API_MSB:`CTRL_API_LSB] == 3'h0); // [RULE21]
  assign word = {msb, dtm_rx_byte_in}; // [RULE2]
  assign cap = (max_pwr < `DTM_MAX_DBM) ? max_pwr : `DTM_MAX_DBM;
  // A request above what the radio can make is cut down to what it can make.
  assign applied = (word[7:2] > cap) ? cap : word[7:2]; // [RULE4] [RULE5]

  always_comb begin
    next_have_msb = have_msb;
    next_msb = msb;
    next_lsb_pending = 1'b0;
    next_lsb = lsb;
    next_dtm_tx = dtm_tx;
    next_dtm_rx = dtm_rx;
    next_carrier = carrier;
    next_dtm_power = dtm_power;
    next_tx_valid = lsb_pending;
    next_tx_byte = lsb_pending ? lsb : 8'h00;
    answer = 16'h0000;
    if (dtm_rx_valid_in && dtm_route) begin
      if (!have_msb) begin
        next_have_msb = 1'b1;
        next_msb = dtm_rx_byte_in;
      end else begin
        next_have_msb = 1'b0; // [RULE1]
        // Fields: [15:14] command, [13:8] control, [7:2] parameter, [1:0] zero.
        unique case (word[15:14]) // [RULE3]
          2'b00: begin
            if (word[13:8] == `DTM_CTRL_POWER) begin
              next_dtm_power = applied;
              answer = {9'h000, applied, 1'b0}; // [RULE5]
            end else if (word[13:8] == `DTM_CTRL_OVERRIDE) begin
              if (word[7:2] > 6'h01) begin
                answer = `DTM_ERR_RSP;
              end else begin
                next_carrier = word[2]; // [RULE6]
              end
            end
          end
          2'b01: begin
            next_dtm_rx = 1'b1;
            next_dtm_tx = 1'b0;
          end
          2'b10: begin
            next_dtm_tx = 1'b1;
            next_dtm_rx = 1'b0;
          end
          2'b11: begin
            next_dtm_tx = 1'b0;
            next_dtm_rx = 1'b0;
            answer = `DTM_END_RSP;
          end
        endcase
        next_tx_valid = 1'b1;
        next_tx_byte = answer[15:8]; // [RULE2]
        next_lsb = answer[7:0];
        next_lsb_pending = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      have_msb <= 1'b0;
      msb <= 8'h00;
      lsb_pending <= 1'b0;
      lsb <= 8'h00;
      dtm_tx <= 1'b0;
      dtm_rx <= 1'b0;
      carrier <= 1'b0;
      dtm_power <= 6'h00;
      dtm_tx_valid_out <= 1'b0;
      dtm_tx_byte_out <= 8'h00;
    end else begin
      have_msb <= next_have_msb;
      msb <= next_msb;
      lsb_pending <= next_lsb_pending;
      lsb <= next_lsb;
      dtm_tx <= next_dtm_tx;
      dtm_rx <= next_dtm_rx;
      carrier <= next_carrier;
      dtm_power <= next_dtm_power;
      dtm_tx_valid_out <= next_tx_valid;
      dtm_tx_byte_out <= next_tx_byte;
    end
  end

  // =========================================================================
  // Radio and status outputs, all registered.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      radio_ctl_out <= '0;
      modem_on_out <= 1'b1;
      feature_enable_out <= 1'b0;
      cellular_normal_out <= 1'b1;
      association_indication_out <= `AI_IDLE;
    end else begin
      radio_ctl_out.tx_on <= next_at_tx | next_dtm_tx;
      radio_ctl_out.rx_on <= next_at_rx | next_dtm_rx;
      radio_ctl_out.carrier_only <= next_carrier; // [RULE6]
      radio_ctl_out.channel <= next_channel; // [RULE11] [RULE17]
      radio_ctl_out.channel_map <= next_channel_map;
      // Direct test power wins while a direct test runs; else whole dBm only.
      radio_ctl_out.power_dbm <= (next_dtm_tx | next_dtm_rx) ? {2'b00, next_dtm_power} :
                                 next_power[11:4]; // [RULE15]
      modem_on_out <= ~next_ctrl[`CTRL_AIRPLANE]; // [RULE21]
      feature_enable_out <= next_test_enabled; // [RULE7]
      cellular_normal_out <= ~next_test_started; // [RULE10]
      association_indication_out <= next_test_enabled ? `AI_TEST : `AI_IDLE; // [RULE8]
    end
  end

  // =========================================================================
  // Checks.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  ai_report_a: assert property ( // [RULE8]
    association_indication_out == (test_enabled ? `AI_TEST : `AI_IDLE))
    else $error("association indication wrong");
  rsp_pair_a: assert property ( // [RULE1]
    dtm_rx_valid_in && dtm_route && have_msb |=> dtm_tx_valid_out ##1 dtm_tx_valid_out)
    else $error("reply not two bytes");
  early_reject_a: assert property ( // [RULE23]
    at_valid_in && !test_started && at_req_in.cmd == CMD_SET_CHAN
    |=> at_rsp_valid_out && at_rsp_out.err && $stable(channel))
    else $error("early command not rejected");
  set_chan_a: assert property ( // [RULE12]
    at_valid_in && test_started && at_req_in.cmd == CMD_SET_CHAN
    |=> channel == $past(at_req_in.arg))
    else $error("channel not stored");
  get_chan_a: assert property ( // [RULE13]
    at_valid_in && at_req_in.cmd == CMD_GET_CHAN && test_started
    |=> at_rsp_out.data == $past(channel))
    else $error("channel readback wrong");
  dtm_power_a: assert property ( // [RULE4]
    dtm_power <= `DTM_MAX_DBM)
    else $error("dtm power above limit");
  stop_ends_a: assert property ( // [RULE10]
    at_valid_in && test_started && at_req_in.cmd == CMD_STOP
    |=> !at_tx && !at_rx && state == ST_INACTIVE ##1 !radio_ctl_out.tx_on || dtm_tx)
    else $error("stop left a test running");
  tx_start_a: assert property ( // [RULE11]
    at_valid_in && test_started && at_req_in.cmd == CMD_TX_START
    |=> radio_ctl_out.tx_on && radio_ctl_out.channel == channel)
    else $error("transmit not started");
  map_legal_a: assert property ( // [RULE18]
    channel_map == `MAP_GSM || channel_map == `MAP_PCS || channel_map == `MAP_LTE)
    else $error("illegal channel map");
  state_code_a: assert property ( // [RULE22]
    state inside {ST_INACTIVE, ST_TRANSITION, ST_OFF, ST_RECEIVE, ST_TRANSMIT, ST_ERROR})
    else $error("illegal status code");

  tx_reached_c: cover property (state == ST_TRANSITION ##1 state == ST_TRANSMIT);
  rx_via_error_c: cover property (state == ST_ERROR ##[1:40] state == ST_RECEIVE);
  dtm_power_c: cover property (dtm_tx_valid_out && dtm_tx_byte_out == 8'h00 ##1 dtm_tx_valid_out);
  carrier_c: cover property (carrier && radio_ctl_out.tx_on);

endmodule : reg_test_interp

/* core/reg_test_map.svh */
// Offsets, field positions, reset values and fixed codes of the regulatory test interpreter.
`ifndef REG_TEST_MAP_SVH
`define REG_TEST_MAP_SVH
// ===========================================================================
// Register offsets on the plain register port.
`define REG_CTRL 4'h0
`define REG_MAXPWR 4'h4
`define REG_STATUS 4'h8
`define REG_SETTINGS 4'hC
// ===========================================================================
// Control register fields and reset values.
`define CTRL_API_LSB 0
`define CTRL_API_MSB 2
`define CTRL_AIRPLANE 3
`define CTRL_RADIO_EN 4
`define CTRL_USB_LSB 5
`define CTRL_USB_MSB 7
`define CTRL_RESET 8'h00
`define MAXPWR_RESET 6'h11
// ===========================================================================
// Direct test mode codes.
`define DTM_MAX_DBM 6'h11
`define DTM_CTRL_POWER 6'h06
`define DTM_CTRL_OVERRIDE 6'h07
`define DTM_END_RSP 16'h8000
`define DTM_ERR_RSP 16'h0001
// ===========================================================================
// Cellular test codes and limits.
`define AI_TEST 8'h31
`define AI_IDLE 8'hFF
`define PWR_MIN_DBM 8'hD8
`define PWR_MAX_DBM 8'h18
`define PWR_ARG_MAX 16'h0FFF
`define MAP_GSM 3'h0
`define MAP_PCS 3'h1
`define MAP_LTE 3'h4
`endif

/* core/reg_test_pkg.sv */
// Types shared by the regulatory test interpreter and its environment.
package reg_test_pkg;
  // =========================================================================
  // Test state as reported by the status query.
  typedef enum logic [2:0] {
    ST_INACTIVE = 3'b000,
    ST_TRANSITION = 3'b001,
    ST_OFF = 3'b010,
    ST_RECEIVE = 3'b011,
    ST_TRANSMIT = 3'b100,
    ST_ERROR = 3'b101
  } test_state_type;
  // =========================================================================
  // Decoded cellular test commands.
  typedef enum logic [3:0] {
    CMD_ENABLE = 4'h0,
    CMD_START = 4'h1,
    CMD_STOP = 4'h2,
    CMD_TX_START = 4'h3,
    CMD_TX_STOP = 4'h4,
    CMD_SET_CHAN = 4'h5,
    CMD_GET_CHAN = 4'h6,
    CMD_SET_PWR = 4'h7,
    CMD_GET_PWR = 4'h8,
    CMD_RX_START = 4'h9,
    CMD_SET_MAP = 4'hA,
    CMD_GET_MAP = 4'hB,
    CMD_QUERY = 4'hC
  } at_cmd_type;
  // =========================================================================
  // Request, answer and radio control bundles.
  typedef struct packed {
    at_cmd_type cmd;
    logic [15:0] arg;
  } at_req_type;
  typedef struct packed {
    logic err;
    logic [15:0] data;
  } at_rsp_type;
  typedef struct packed {
    logic tx_on;
    logic rx_on;
    logic carrier_only;
    logic [15:0] channel;
    logic [2:0] channel_map;
    logic [7:0] power_dbm;
  } radio_ctl_type;
endpackage : reg_test_pkg

/* test/radio_model.sv */
// Radio partner model: answers each mode request with an ack or a fail after a delay.
`timescale 1ns/1ps
module radio_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rstn_in,
  // Request from the bench.
  input wire logic go_in,
  input wire logic slow_in,
  input wire logic fail_in,
  // Answers to the interpreter.
  output logic ack_out,
  output logic fail_out
);
  int cnt;
  // ==========================================================================
  // Delay counter.
  // A slow answer stands in for a long radio reconfiguration.
  // A fail is only given when the bench asks for one, never at random.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 0;
      ack_out <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
      fail_out <= 1'b0;
      if (go_in) begin
        cnt <= slow_in ? 30 : 2;
      end else if (cnt == 1) begin
        cnt <= 0;
        ack_out <= !fail_in;
        fail_out <= fail_in;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : radio_model

/* test/testbench.sv */
// Self-checking testbench of the regulatory test interpreter.
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  import reg_test_pkg::*;
  logic clk, rst_n, wr, rd, dv, at_v, go, slow, rfail, ack, fail;
  logic [3:0] addr;
  logic [31:0] wd, rdata;
  logic [7:0] db, tb, ai;
  logic tv, rv, modem, feat, norm;
  at_req_type at_rq;
  at_rsp_type rsp;
  radio_ctl_type rc;
  int fails, checks_done, i;
  logic [2:0] maps [3] = '{3'h0, 3'h1, 3'h4};
  // ==========================================================================
  // Design and radio partner.
  reg_test_interp DUT (.core_clk_in(clk), .rstn_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .dtm_rx_valid_in(dv), .dtm_rx_byte_in(db), .dtm_tx_valid_out(tv),
    .dtm_tx_byte_out(tb), .at_valid_in(at_v), .at_req_in(at_rq),
    .at_rsp_valid_out(rv), .at_rsp_out(rsp), .radio_ack_in(ack), .radio_fail_in(fail),
    .radio_ctl_out(rc), .modem_on_out(modem), .feature_enable_out(feat),
    .cellular_normal_out(norm), .association_indication_out(ai));
  radio_model radio (.clk_in(clk), .rstn_in(rst_n), .go_in(go), .slow_in(slow),
    .fail_in(rfail), .ack_out(ack), .fail_out(fail));
  // ==========================================================================
  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks.
  // Case inequality so that an unknown never passes for a match.
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e);
  endtask : rd_chk
  // One command strobe; the answer stands only in the cycle after it.
  task at_send(input at_cmd_type c, input logic [15:0] a);
    @(posedge clk);
    at_v <= 1'b1;
    at_rq <= '{cmd: c, arg: a};
    @(posedge clk);
    at_v <= 1'b0;
    #1;
  endtask : at_send
  // Data is only compared on accepted commands; refused ones carry no data.
  task atx(input at_cmd_type c, input logic [15:0] a, input logic e, input logic [15:0] d);
    at_send(c, a);
    `CHK(rv, 1);
    `CHK(rsp.err, e);
    if (!e) `CHK(rsp.data, d);
  endtask : atx
  // Host polling of the status query, bounded so a stuck state ends the run.
  task poll(input logic [2:0] s);
    for (i = 0; i < 40; i++) begin
      at_send(CMD_QUERY, 16'h0000);
      if (rv === 1'b1 && rsp.data === {13'h0000, s}) break;
    end
    `CHK(rsp.data, s);
    if (i == 40) tally_and_finish();
  endtask : poll
  task rgo(input logic f, input logic s);
    @(posedge clk);
    go <= 1'b1;
    rfail <= f;
    slow <= s;
    @(posedge clk);
    go <= 1'b0;
  endtask : rgo
  // Sends one command MSB first; on expects a two-byte reply, else silence.
  task dtm(input logic [15:0] c, input logic [15:0] e, input logic on);
    @(posedge clk);
    dv <= 1'b1;
    db <= c[15:8];
    @(posedge clk);
    db <= c[7:0];
    @(posedge clk);
    dv <= 1'b0;
    #1;
    `CHK(tv, on);
    if (on) `CHK(tb, e[15:8]);
    @(posedge clk);
    #1;
    `CHK(tv, on);
    if (on) `CHK(tb, e[7:0]);
  endtask : dtm
  // ==========================================================================
  // Main sequence.
  initial begin
    {rst_n, wr, rd, dv, at_v, go, slow, rfail} = '0;
    {addr, wd, db} = '0;
    at_rq = '0;
    fails = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(ai, 8'hFF);
    `CHK(feat, 0);
    rd_chk(4'h8, 32'h0000_FF00);
    rd_chk(4'h4, 32'h11);
    rd_chk(4'h2, 32'h0);
    atx(CMD_START, 16'h0, 1'b1, 16'h0);
    atx(CMD_ENABLE, 16'h2, 1'b1, 16'h0);
    atx(CMD_ENABLE, 16'h1, 1'b0, 16'h0);
    atx(CMD_SET_CHAN, 16'h7, 1'b1, 16'h0);
    `CHK({feat, ai}, 9'h131);
    atx(CMD_START, 16'h0, 1'b0, 16'h0);
    poll(3'h1);
    rgo(1'b0, 1'b0);
    poll(3'h2);
    `CHK(norm, 0);
    rd_chk(4'h8, 32'h311A);
    atx(CMD_SET_CHAN, 16'hFFFF, 1'b0, 16'h0);
    atx(CMD_GET_CHAN, 16'h0, 1'b0, 16'hFFFF);
    atx(CMD_SET_PWR, 16'h1000, 1'b1, 16'h0);
    atx(CMD_SET_PWR, 16'h0190, 1'b1, 16'h0);
    atx(CMD_SET_PWR, 16'h0D70, 1'b1, 16'h0);
    atx(CMD_SET_PWR, 16'h0180, 1'b0, 16'h0);
    `CHK(rc.power_dbm, 8'h18);
    atx(CMD_SET_PWR, 16'h0FF8, 1'b0, 16'h0);
    `CHK(rc.power_dbm, 8'hFF);
    atx(CMD_SET_PWR, 16'h0D80, 1'b0, 16'h0);
    atx(CMD_GET_PWR, 16'h0, 1'b0, 16'h0D80);
    foreach (maps[k]) begin
      atx(CMD_SET_MAP, {13'h0, maps[k]}, 1'b0, 16'h0);
      atx(CMD_GET_MAP, 16'h0, 1'b0, {13'h0, maps[k]});
    end
    atx(CMD_SET_MAP, 16'h2, 1'b1, 16'h0);
    atx(CMD_GET_MAP, 16'h0, 1'b0, 16'h4);
    atx(CMD_SET_CHAN, 16'd5110, 1'b0, 16'h0);
    atx(CMD_TX_START, 16'h0, 1'b0, 16'h0);
    @(posedge clk);
    #1;
    `CHK({rc.tx_on, rc.channel, rc.power_dbm}, {1'b1, 16'd5110, 8'hD8});
    rgo(1'b0, 1'b0);
    poll(3'h4);
    atx(CMD_TX_STOP, 16'h0, 1'b0, 16'h0);
    @(posedge clk);
    #1;
    `CHK(rc.tx_on, 0);
    poll(3'h2);
    rd_chk(4'hC, 32'h0D80_13F6);
    atx(CMD_RX_START, 16'h0, 1'b0, 16'h0);
    @(posedge clk);
    #1;
    `CHK({rc.rx_on, rc.channel}, {1'b1, 16'd5110});
    rgo(1'b1, 1'b1);
    poll(3'h5);
    rgo(1'b0, 1'b1);
    poll(3'h3);
    atx(CMD_STOP, 16'h0, 1'b0, 16'h0);
    @(posedge clk);
    #1;
    `CHK({rc.rx_on, norm}, 2'b01);
    atx(CMD_SET_CHAN, 16'h1, 1'b1, 16'h0);
    atx(CMD_ENABLE, 16'h0, 1'b0, 16'h0);
    `CHK({feat, ai}, 9'h0FF);
    wr_reg(4'h0, 32'h09);
    #1;
    `CHK(modem, 0);
    dtm(16'h0628, 16'h0, 1'b0);
    wr_reg(4'h0, 32'h00);
    #1;
    `CHK(modem, 1);
    dtm(16'h0628, 16'h0014, 1'b1);
    wr_reg(4'h4, 32'h05);
    dtm(16'h0628, 16'h000A, 1'b1);
    wr_reg(4'h4, 32'h11);
    dtm(16'h0644, 16'h0022, 1'b1);
    dtm(16'h0648, 16'h0022, 1'b1);
    dtm(16'h0704, 16'h0000, 1'b1);
    `CHK(rc.carrier_only, 1);
    dtm(16'h0708, 16'h0001, 1'b1);
    `CHK(rc.carrier_only, 1);
    dtm(16'h0700, 16'h0000, 1'b1);
    `CHK(rc.carrier_only, 0);
    dtm(16'h0204, 16'h0000, 1'b1);
    dtm(16'h80FD, 16'h0000, 1'b1);
    `CHK({rc.tx_on, rc.power_dbm}, {1'b1, 8'h11});
    dtm(16'hC000, 16'h8000, 1'b1);
    `CHK(rc.tx_on, 0);
    tally_and_finish();
  end
endmodule : testbench
